// ---- rtl/uebc_core.sv ----
// Endpoint buffering core: bulk/control/iso buffers, fast moves, irqs.
// Assumes the serial engine delivers decoded tokens and bytes on clk.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Bulk IN and OUT of one number map to separate buffers.
// - Bulk packet size selectable 8/16/32/64; buffer limit follows it.
// - Fourteen bulk endpoints 1..7 each way, 64 bytes each.
// - Endpoint 0 has both IN and OUT buffers.
// - SETUP tokens accepted only on endpoint 0.
// - Control transfer is SETUP of eight bytes, optional data, handshake.
// - Endpoint 0 is sole control endpoint; requests flagged to processor.
// - Endpoints 1..7 also serve as interrupt endpoints, same access.
// - Eight isochronous endpoints 8..15 each direction.
// - Isochronous endpoints share one 1024-byte pool, double buffered.
// - Processor uses previous-frame bank while host uses the other.
// - Isochronous banks swap at every start-of-frame.
// - Fast mode moves one byte per external move, 333 ns.
// - Fast moves drive external FIFO read and write strobes.
// - Fast mode works on isochronous and bulk endpoints.
// - Seven added interrupt sources: three internal, four from pins.
// - One USB event line, one two-wire serial line, one wakeup line.
// - USB interrupt vector identifies the requesting endpoint.
// - Isochronous endpoints have no own interrupt; serviced at SOF.
// - Four reset sources: power-on, bus reset, processor, reconnect.
// - Suspend may stop the oscillator and enter sleep.
// - Wake pin or bus resume restarts oscillator and interrupts.
module uebc_core
  import uebc_pkg::*;
#(
  parameter int FAST_CYC = FAST_MOVE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sie_tok_valid,
  input wire logic sie_tok_setup,
  input wire logic sie_tok_in,
  input wire logic [3:0] sie_tok_ep,
  input wire logic sie_rx_valid,
  input wire logic [7:0] sie_rx_data,
  input wire logic sie_tx_req,
  input wire logic sie_pkt_end,
  input wire logic sie_sof,
  input wire logic sie_bus_reset,
  input wire logic sie_suspend,
  input wire logic sie_resume,
  input wire logic discon_event,
  input wire logic cpu_reset,
  input wire logic [31:0] ep_size_sel,
  input wire logic [4:0] cpu_ep,
  input wire logic [5:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic external_move_instruction,
  input wire logic fast_to_ext,
  input wire logic [7:0] ext_data_in,
  input wire logic irq_ack,
  input wire logic twi_event,
  input wire logic twi_ack,
  input wire logic wake_pin,
  input wire logic wake_ack,
  input wire logic suspend_en,
  input wire logic [EXT_IRQ_W-1:0] ext_irq_pin,
  output logic tok_ack,
  output logic tok_reject,
  output logic [7:0] sie_tx_data,
  output logic [6:0] sie_rx_count,
  output logic [7:0] cpu_rdata,
  output logic [7:0] ext_data_out,
  output logic ext_data_oe,
  output logic fifo_rd_n,
  output logic fifo_wr_n,
  output logic fast_busy,
  output logic usb_event_irq,
  output logic [4:0] usb_vector,
  output logic two_wire_serial_irq,
  output logic wakeup_irq,
  output logic [EXT_IRQ_W-1:0] ext_irq,
  output logic osc_run,
  output logic iso_bank
);
  // Slot of a bulk/control endpoint, IN and OUT kept apart
  function automatic logic [3:0] bulk_slot(input logic in,
                                           input logic [3:0] num);
    logic [3:0] n;
    n = {1'b0, num[2:0]};
    if (num == 4'h0) begin
      bulk_slot = in ? SLOT_EP0_IN : SLOT_EP0_OUT;
    end else begin
      bulk_slot = in ? n + SLOT_IN_BASE : n - SLOT_OUT_BASE;
    end
  endfunction

  // Byte limit of a slot from its 2-bit packet size code
  function automatic logic [6:0] pkt_limit(input logic [1:0] sel);
    pkt_limit = PKT_MIN_BYTES << sel;
  endfunction

  logic clr;
  logic cur_act_reg, cur_in_reg, cur_setup_reg;
  logic [3:0] cur_ep_reg;
  logic [6:0] sie_off_reg;
  logic [PEND_W-1:0] pend_reg, pend_set, pend_clr, pend_next;
  logic [4:0] vec_next;
  logic [7:0] ext_sync;
  logic wake_sync;
  logic [EXT_IRQ_W-1:0] ext_irq_sync;
  uebc_fm_e fm_reg;
  logic [5:0] fm_cnt_reg;
  logic fm_dir_reg;

  // Any of the four reset sources clears endpoint state
  assign clr = !nrst || sie_bus_reset || discon_event || cpu_reset;

  // Pin inputs pass two flops
  uebc_sync #(.W(8)) u_sync_data (
    .clk(clk), .nrst(nrst), .d(ext_data_in), .q(ext_sync)
  );
  uebc_sync #(.W(1 + EXT_IRQ_W)) u_sync_pins (
    .clk(clk), .nrst(nrst), .d({wake_pin, ext_irq_pin}),
    .q({wake_sync, ext_irq_sync})
  );

  // Serial side addressing
  wire sie_iso = cur_ep_reg[3];
  wire [3:0] sie_slot = bulk_slot(cur_in_reg, cur_ep_reg);
  wire [6:0] sie_lim = sie_iso ? ISO_SLOT_BYTES :
                       pkt_limit(ep_size_sel[{sie_slot, 1'b0} +: 2]);
  wire sie_room = sie_off_reg < sie_lim;
  wire [9:0] sie_bulk_addr = {sie_slot, sie_off_reg[5:0]};
  wire [9:0] sie_iso_addr = {iso_bank, cur_in_reg, cur_ep_reg[2:0],
                             sie_off_reg[4:0]};
  wire sie_wr = cur_act_reg && !cur_in_reg && sie_rx_valid && sie_room;
  wire sie_rd = cur_act_reg && cur_in_reg && sie_tx_req && sie_room;
  wire tok_ok = !sie_tok_setup || (sie_tok_ep == 4'h0);

  // Processor side addressing, shared by plain and fast access
  wire cpu_iso = cpu_ep[3];
  wire [3:0] cpu_slot = bulk_slot(cpu_ep[4], cpu_ep[3:0]);
  wire [9:0] cpu_bulk_addr = {cpu_slot, cpu_addr};
  wire [9:0] cpu_iso_addr = {~iso_bank, cpu_ep[4], cpu_ep[2:0],
                             cpu_addr[4:0]};
  wire fm_wr = (fm_reg == UEBC_FM_DONE) && !fm_dir_reg;
  wire cpu_we = cpu_wr || fm_wr;
  wire [7:0] cpu_wbyte = fm_wr ? ext_sync : cpu_wdata;
  wire [7:0] bulk_sie_q, bulk_cpu_q, iso_sie_q, iso_cpu_q;
  wire [7:0] cpu_q = cpu_iso ? iso_cpu_q : bulk_cpu_q;

  // Bulk and control buffers
  uebc_dpram #(.W(8), .D(BULK_DEPTH), .AW(10)) u_bulk (
    .clk(clk),
    .a_we(sie_wr && !sie_iso), .a_addr(sie_bulk_addr),
    .a_wdata(sie_rx_data), .a_rdata(bulk_sie_q),
    .b_we(cpu_we && !cpu_iso), .b_addr(cpu_bulk_addr),
    .b_wdata(cpu_wbyte), .b_rdata(bulk_cpu_q)
  );

  // Isochronous ping-pong pool
  uebc_dpram #(.W(8), .D(ISO_POOL_BYTES), .AW(10)) u_iso (
    .clk(clk),
    .a_we(sie_wr && sie_iso), .a_addr(sie_iso_addr),
    .a_wdata(sie_rx_data), .a_rdata(iso_sie_q),
    .b_we(cpu_we && cpu_iso), .b_addr(cpu_iso_addr),
    .b_wdata(cpu_wbyte), .b_rdata(iso_cpu_q)
  );

  // Token acceptance and current transaction
  always_ff @(posedge clk) begin
    if (clr) begin
      tok_ack <= 1'b0;
      tok_reject <= 1'b0;
      cur_act_reg <= 1'b0;
      cur_in_reg <= 1'b0;
      cur_setup_reg <= 1'b0;
      cur_ep_reg <= 4'h0;
    end else begin
      tok_ack <= sie_tok_valid && tok_ok;
      tok_reject <= sie_tok_valid && !tok_ok;
      if (sie_tok_valid && tok_ok) begin
        cur_act_reg <= 1'b1;
        cur_in_reg <= sie_tok_in && !sie_tok_setup;
        cur_setup_reg <= sie_tok_setup;
        cur_ep_reg <= sie_tok_ep;
      end else if (sie_pkt_end) begin
        cur_act_reg <= 1'b0;
      end
    end
  end

  // Byte offset and byte data toward the serial engine
  always_ff @(posedge clk) begin
    if (clr || (sie_tok_valid && tok_ok)) begin
      sie_off_reg <= 7'h00;
    end else if (sie_wr || sie_rd) begin
      sie_off_reg <= sie_off_reg + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      sie_tx_data <= 8'h00;
      sie_rx_count <= 7'h00;
    end else begin
      if (sie_rd) begin
        sie_tx_data <= sie_iso ? iso_sie_q : bulk_sie_q;
      end
      if (sie_pkt_end && cur_act_reg) begin
        sie_rx_count <= sie_off_reg;
      end
    end
  end

  // Iso bank pointer: one flop swaps every endpoint at once
  always_ff @(posedge clk) begin
    if (!nrst) begin
      iso_bank <= RST_ISO_BANK;
    end else if (sie_sof) begin
      iso_bank <= ~iso_bank;
    end
  end

  // Pending events: endpoints, setup, start-of-frame; set beats clear
  always_comb begin
    pend_set = '0;
    pend_clr = '0;
    if (sie_pkt_end && cur_act_reg && !sie_iso) begin
      pend_set[sie_slot] = 1'b1;
      pend_set[PEND_SETUP] = cur_setup_reg;
    end
    pend_set[PEND_SOF] = sie_sof;
    if (irq_ack && usb_event_irq) begin
      pend_clr[usb_vector] = 1'b1;
    end
    pend_next = (pend_reg & ~pend_clr) | pend_set;
  end

  // Vector of the lowest pending source
  always_comb begin
    vec_next = 5'h00;
    for (int i = PEND_W - 1; i >= 0; i--) begin
      if (pend_next[i]) begin
        vec_next = 5'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      pend_reg <= '0;
      usb_event_irq <= 1'b0;
      usb_vector <= 5'h00;
    end else begin
      pend_reg <= pend_next;
      usb_event_irq <= |pend_next;
      usb_vector <= vec_next;
    end
  end

  // Processor read data
  always_ff @(posedge clk) begin
    if (clr) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata <= cpu_q;
    end
  end

  // Fast move sequencer: one byte per move, strobe held for the move
  always_ff @(posedge clk) begin
    if (clr) begin
      fm_reg <= UEBC_FM_IDLE;
      fm_cnt_reg <= RST_FAST_CNT;
      fm_dir_reg <= 1'b0;
      fast_busy <= 1'b0;
      fifo_rd_n <= 1'b1;
      fifo_wr_n <= 1'b1;
      ext_data_oe <= 1'b0;
      ext_data_out <= 8'h00;
    end else begin
      unique case (fm_reg)
        UEBC_FM_IDLE: begin
          if (external_move_instruction) begin
            fm_reg <= UEBC_FM_STROBE;
            fm_cnt_reg <= 6'(FAST_CYC - 2);
            fm_dir_reg <= fast_to_ext;
            fast_busy <= 1'b1;
            fifo_rd_n <= !fast_to_ext;
            fifo_wr_n <= fast_to_ext;
            ext_data_oe <= fast_to_ext;
            ext_data_out <= fast_to_ext ? cpu_q : 8'h00;
          end
        end
        UEBC_FM_STROBE: begin
          if (fm_cnt_reg == 6'h00) begin
            fm_reg <= UEBC_FM_DONE;
          end else begin
            fm_cnt_reg <= fm_cnt_reg - 6'h01;
          end
        end
        UEBC_FM_DONE: begin
          fm_reg <= UEBC_FM_IDLE;
          fast_busy <= 1'b0;
          fifo_rd_n <= 1'b1;
          fifo_wr_n <= 1'b1;
          ext_data_oe <= 1'b0;
        end
        default: begin
          fm_reg <= UEBC_FM_IDLE;
        end
      endcase
    end
  end

  // Serial interface and pin interrupts, oscillator and wakeup
  always_ff @(posedge clk) begin
    if (!nrst) begin
      two_wire_serial_irq <= 1'b0;
      wakeup_irq <= 1'b0;
      ext_irq <= '0;
      osc_run <= RST_OSC_RUN;
    end else begin
      two_wire_serial_irq <= twi_event ||
                             (two_wire_serial_irq && !twi_ack);
      ext_irq <= ext_irq_sync;
      if (!osc_run && (wake_sync || sie_resume)) begin
        osc_run <= 1'b1;
        wakeup_irq <= 1'b1;
      end else begin
        if (osc_run && sie_suspend && suspend_en) begin
          osc_run <= 1'b0;
        end
        wakeup_irq <= wakeup_irq && !wake_ack;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (clr);

  setup_ep0_only_a: assert property (sie_tok_valid && sie_tok_setup &&
      sie_tok_ep != 4'h0 |=> tok_reject && !tok_ack)
    else $error("setup accepted off endpoint zero");
  ep0_out_ok_a: assert property (sie_tok_valid && !sie_tok_setup &&
      sie_tok_ep == 4'h0 |=> tok_ack)
    else $error("endpoint zero token refused");
  bank_swap_a: assert property (sie_sof |=> iso_bank != $past(iso_bank))
    else $error("iso bank did not swap at frame start");
  // Busy stretch length, counted so the check follows FAST_CYC
  logic [5:0] busy_len_reg;
  always_ff @(posedge clk) begin
    if (clr || !fast_busy) begin
      busy_len_reg <= 6'h00;
    end else begin
      busy_len_reg <= busy_len_reg + 6'h01;
    end
  end

  fast_len_a: assert property ($fell(fast_busy) |->
      busy_len_reg == 6'(FAST_CYC))
    else $error("fast move length wrong");
  strobe_drive_a: assert property (!fifo_rd_n |-> ext_data_oe &&
      fifo_wr_n && fast_busy)
    else $error("read strobe without driven data");
  ep_vector_a: assert property (sie_pkt_end && cur_act_reg &&
      !sie_iso |=> usb_event_irq && pend_reg[$past(sie_slot)])
    else $error("endpoint event not pending");
  iso_quiet_a: assert property (sie_pkt_end && cur_act_reg && sie_iso &&
      pend_reg == '0 && !sie_sof |=> !usb_event_irq)
    else $error("iso endpoint raised its own interrupt");
  sleep_a: assert property (osc_run && sie_suspend && suspend_en &&
      !sie_resume |=> !osc_run)
    else $error("oscillator kept running in suspend");
  wake_a: assert property (!osc_run && sie_resume |=>
      osc_run && wakeup_irq)
    else $error("resume did not wake");
  twi_line_a: assert property (twi_event |=> two_wire_serial_irq)
    else $error("two-wire event lost");

  setup_seen_c: cover property (tok_ack && cur_setup_reg ##[1:20] sie_pkt_end);
  swap_seen_c: cover property (sie_sof ##[1:1000] sie_sof);
  fast_done_c: cover property ($fell(fast_busy));
  wake_seen_c: cover property ($rose(wakeup_irq));
endmodule
`default_nettype wire

// ---- rtl/uebc_pkg.sv ----
// Package of the endpoint buffer core: sizes, slot codes, timing counts.
// Assumes a single 100 MHz processor clock for the whole core.
package uebc_pkg;
  // Clock and fast move timing
  localparam int CLK_NS = 10;
  localparam int FAST_MOVE_NS = 333;
  localparam int FAST_MOVE_CYC = (FAST_MOVE_NS + CLK_NS - 1) / CLK_NS;
  // Bulk / control buffer layout: 16 slots of 64 bytes
  localparam int BULK_EP_CNT = 14;
  localparam int BULK_BUF_BYTES = 64;
  localparam int BULK_SLOTS = 16;
  localparam int BULK_DEPTH = BULK_SLOTS * BULK_BUF_BYTES;
  localparam logic [3:0] SLOT_EP0_IN = 4'he;
  localparam logic [3:0] SLOT_EP0_OUT = 4'hf;
  localparam logic [3:0] SLOT_IN_BASE = 4'h6;
  localparam logic [3:0] SLOT_OUT_BASE = 4'h1;
  // Isochronous pool: two banks, 16 endpoints, 32 bytes each per bank
  localparam int ISO_POOL_BYTES = 1024;
  localparam logic [6:0] ISO_SLOT_BYTES = 7'h20;
  localparam logic [6:0] PKT_MIN_BYTES = 7'h08;
  // Interrupt pending vector layout
  localparam int PEND_W = 18;
  localparam int PEND_SETUP = 16;
  localparam int PEND_SOF = 17;
  localparam int EXT_IRQ_W = 4;
  // Reset values
  localparam logic RST_ISO_BANK = 1'b0;
  localparam logic RST_OSC_RUN = 1'b1;
  localparam logic [5:0] RST_FAST_CNT = 6'h00;
  // Fast move sequencer
  typedef enum logic [2:0] {
    UEBC_FM_IDLE = 3'b001,
    UEBC_FM_STROBE = 3'b010,
    UEBC_FM_DONE = 3'b100
  } uebc_fm_e;
endpackage

// ---- rtl/uebc_sync.sv ----
// Two flip-flop synchroniser for pins entering the clock domain.
// Assumes the input bits are independent levels.
`timescale 1ns/1ps
`default_nettype none
module uebc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/uebc_dpram.sv ----
// Flip-flop buffer memory with two write/read ports and async reads.
// Assumes port a wins when both ports write the same address.
`timescale 1ns/1ps
`default_nettype none
module uebc_dpram #(
  parameter int W = 8,
  parameter int D = 1024,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [W-1:0] a_wdata,
  output logic [W-1:0] a_rdata,
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [W-1:0] b_wdata,
  output logic [W-1:0] b_rdata
);
  logic [W-1:0] mem [D];

  // Reads by index
  assign a_rdata = mem[a_addr];
  assign b_rdata = mem[b_addr];

  // Later assignment gives port a priority
  always_ff @(posedge clk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end
endmodule
`default_nettype wire

// ---- bench/uebc_ext_fifo_model.sv ----
// External FIFO logic model sitting on the fast transfer data bus.
// Assumes active-low strobes from the core, sampled on the core clock.
`timescale 1ns/1ps
`default_nettype none
module uebc_ext_fifo_model (
  input wire logic clk,
  input wire logic fifo_rd_n,
  input wire logic fifo_wr_n,
  input wire logic ext_data_oe,
  input wire logic [7:0] ext_data_out,
  input wire logic [7:0] src_byte,
  output logic [7:0] ext_data_in,
  output logic [7:0] got_byte,
  output logic got_valid
);
  logic rd_n_d = 1'b1;
  initial begin
    ext_data_in = 8'h00;
    got_byte = 8'h00;
    got_valid = 1'b0;
  end
  // Offer the byte only while the write strobe is low, else scramble
  always @(posedge clk) begin
    #1;
    if (!fifo_wr_n) begin
      ext_data_in = src_byte;
    end else begin
      ext_data_in = ~ext_data_in;
    end
  end
  // Take the driven byte while the read strobe is low
  always @(posedge clk) begin
    got_valid <= fifo_rd_n && !rd_n_d;
    if (!fifo_rd_n && ext_data_oe) begin
      got_byte <= ext_data_out;
    end
    rd_n_d <= fifo_rd_n;
  end
endmodule
`default_nettype wire

// ---- bench/usb_endpoint_buffer_core_test.sv ----
// Self-checking bench of the endpoint buffer core.
// Assumes the external FIFO model stands on the fast transfer bus.
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_buffer_core_test import uebc_pkg::*; ;
  localparam int FC = 6;
  logic clk = 0, nrst = 0, sie_tok_valid = 0, sie_tok_setup = 0;
  logic sie_tok_in = 0, sie_rx_valid = 0, sie_tx_req = 0, sie_pkt_end = 0;
  logic sie_sof = 0, sie_bus_reset = 0, sie_suspend = 0, sie_resume = 0;
  logic discon_event = 0, cpu_reset = 0, cpu_wr = 0, cpu_rd = 0;
  logic external_move_instruction = 0, fast_to_ext = 0, irq_ack = 0;
  logic twi_event = 0, twi_ack = 0, wake_pin = 0, wake_ack = 0;
  logic suspend_en = 0;
  logic [3:0] sie_tok_ep = 0, ext_irq_pin = 0, ext_irq;
  logic [7:0] sie_rx_data = 0, cpu_wdata = 0, src_byte = 0, ext_data_in;
  logic [4:0] cpu_ep = 0, usb_vector;
  logic [5:0] cpu_addr = 0;
  logic [31:0] ep_size_sel = 32'hffffffff;
  logic tok_ack, tok_reject, ext_data_oe, fifo_rd_n, fifo_wr_n, fast_busy;
  logic usb_event_irq, two_wire_serial_irq, wakeup_irq, osc_run, iso_bank;
  logic got_valid;
  logic [7:0] sie_tx_data, cpu_rdata, ext_data_out, got_byte;
  logic [6:0] sie_rx_count;
  uebc_core #(.FAST_CYC(FC)) dut (.clk, .nrst, .sie_tok_valid,
    .sie_tok_setup, .sie_tok_in, .sie_tok_ep, .sie_rx_valid, .sie_rx_data,
    .sie_tx_req, .sie_pkt_end, .sie_sof, .sie_bus_reset, .sie_suspend,
    .sie_resume, .discon_event, .cpu_reset, .ep_size_sel, .cpu_ep,
    .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .external_move_instruction,
    .fast_to_ext, .ext_data_in, .irq_ack, .twi_event, .twi_ack, .wake_pin,
    .wake_ack, .suspend_en, .ext_irq_pin, .tok_ack, .tok_reject,
    .sie_tx_data, .sie_rx_count, .cpu_rdata, .ext_data_out, .ext_data_oe,
    .fifo_rd_n, .fifo_wr_n, .fast_busy, .usb_event_irq, .usb_vector,
    .two_wire_serial_irq, .wakeup_irq, .ext_irq, .osc_run, .iso_bank);
  uebc_ext_fifo_model ext (.clk, .fifo_rd_n, .fifo_wr_n, .ext_data_oe,
    .ext_data_out, .src_byte, .ext_data_in, .got_byte, .got_valid);
  typedef struct {string n; logic [7:0] v;} uebc_exp_s;
  uebc_exp_s exp_q[$];
  logic [7:0] obs_val;
  logic [7:0] pkt [66];
  logic [31:0] rs = 32'h000131c4;
  event obs_ev;
  int fail_count = 0, tests_run = 0, cyc = 0;
  // Clock at 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Checker process: oldest note against each observed result
  always @(obs_ev) begin
    uebc_exp_s e;
    e = exp_q.pop_front();
    tests_run++;
    if (e.v !== obs_val) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", e.n, e.v, obs_val);
    end
  end
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  task automatic look(input string n, input logic [7:0] v, g);
    exp_q.push_back('{n, v});
    obs_val = g;
    ->obs_ev;
    #0;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick();
    s = 0;
  endtask
  task automatic token(input logic s, i, input logic [3:0] ep, input logic ok);
    sie_tok_valid = 1;
    sie_tok_setup = s;
    sie_tok_in = i;
    sie_tok_ep = ep;
    tick();
    sie_tok_valid = 0;
    look("tok_ack", 8'(ok), 8'(tok_ack));
    look("tok_reject", 8'(!ok), 8'(tok_reject));
  endtask
  task automatic send_out(input int n);
    for (int k = 0; k < n; k++) begin
      pkt[k] = rnd();
      sie_rx_valid = 1;
      sie_rx_data = pkt[k];
      tick();
    end
    sie_rx_valid = 0;
    pulse(sie_pkt_end);
  endtask
  task automatic rd(input logic [4:0] ep, input logic [5:0] a, input logic [7:0] v);
    cpu_ep = ep;
    cpu_addr = a;
    pulse(cpu_rd);
    look("cpu_rdata", v, cpu_rdata);
  endtask
  task automatic irq_is(input logic [7:0] v);
    tick();
    look("usb_event_irq", v, 8'(usb_event_irq));
  endtask
  task automatic fast(input logic to_ext);
    int n = 0;
    fast_to_ext = to_ext;
    pulse(external_move_instruction);
    look("strobe_n", 8'h0, 8'(to_ext ? fifo_rd_n : fifo_wr_n));
    look("ext_data_oe", 8'(to_ext), 8'(ext_data_oe));
    while (fast_busy === 1'b1 && n < 100) begin
      n++;
      external_move_instruction = (n == 2);
      tick();
    end
    external_move_instruction = 0;
    look("busy_cycles", 8'(FC), 8'(n));
    tick();
    look("idle", 8'h3, {5'h0, fast_busy, fifo_rd_n, fifo_wr_n});
  endtask
  // Main sequence
  initial begin
    tick(8);
    look("reset_outs", 8'h1c, {3'h0, fifo_rd_n, fifo_wr_n, osc_run, iso_bank,
      usb_event_irq});
    nrst = 1;
    for (int c = 0; c < 4; c++) begin
      ep_size_sel[3:2] = 2'(c);
      token(0, 0, 4'h2, 1);
      send_out((8 << c) + 2);
      look("rx_count", 8'(PKT_MIN_BYTES << c), 8'(sie_rx_count));
      irq_is(1);
      look("usb_vector", 8'h01, 8'(usb_vector));
      rd(5'h02, 6'((8 << c) - 1), pkt[(8 << c) - 1]);
      pulse(irq_ack);
      irq_is(0);
    end
    cpu_ep = 5'h12;
    cpu_addr = 6'h00;
    cpu_wdata = 8'h5a;
    pulse(cpu_wr);
    token(0, 1, 4'h2, 1);
    pulse(sie_tx_req);
    look("sie_tx_data", 8'h5a, sie_tx_data);
    pulse(sie_pkt_end);
    irq_is(1);
    look("usb_vector", 8'h08, 8'(usb_vector));
    rd(5'h02, 6'h00, pkt[0]);
    pulse(irq_ack);
    token(1, 0, 4'h3, 0);
    token(1, 0, 4'h0, 1);
    send_out(8);
    look("rx_count", 8'h08, 8'(sie_rx_count));
    irq_is(1);
    rd(5'h00, 6'h07, pkt[7]);
    for (int r = 0; r < 3; r++) begin
      if (r == 0) pulse(sie_bus_reset);
      else if (r == 1) pulse(cpu_reset);
      else pulse(discon_event);
      irq_is(0);
      token(0, 0, 4'h1, 1);
      send_out(2);
      irq_is(1);
    end
    pulse(irq_ack);
    token(0, 0, 4'h9, 1);
    send_out(3);
    irq_is(0);
    pulse(sie_sof);
    look("iso_bank", 8'h1, 8'(iso_bank));
    irq_is(1);
    look("usb_vector", 8'h11, 8'(usb_vector));
    rd(5'h09, 6'h02, pkt[2]);
    cpu_ep = 5'h19;
    cpu_addr = 6'h00;
    cpu_wdata = 8'ha7;
    pulse(cpu_wr);
    pulse(irq_ack);
    pulse(sie_sof);
    look("iso_bank", 8'h0, 8'(iso_bank));
    token(0, 1, 4'h9, 1);
    pulse(sie_tx_req);
    look("sie_tx_data", 8'ha7, sie_tx_data);
    cpu_wdata = 8'h3c;
    pulse(cpu_wr);
    fast(1);
    look("got_byte", 8'h3c, got_byte);
    src_byte = rnd();
    fast(0);
    rd(5'h19, 6'h00, src_byte);
    pulse(twi_event);
    tick();
    look("twi_irq", 8'h1, 8'(two_wire_serial_irq));
    pulse(twi_ack);
    tick();
    look("twi_irq", 8'h0, 8'(two_wire_serial_irq));
    ext_irq_pin = 4'ha;
    tick(5);
    look("ext_irq", 8'h0a, 8'(ext_irq));
    for (int w = 0; w < 2; w++) begin
      sie_suspend = 1;
      suspend_en = 1;
      tick(2);
      look("osc_run", 8'h0, 8'(osc_run));
      sie_suspend = 0;
      if (w == 0) pulse(sie_resume);
      else pulse(wake_pin);
      tick(4);
      look("wake", 8'h3, {6'h0, osc_run, wakeup_irq});
      pulse(wake_ack);
      tick();
      look("wakeup_irq", 8'h0, 8'(wakeup_irq));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
